// ===== testbench/pdrf_host.sv
// bus master model of the host writing configuration words
`timescale 1ns/100ps
`default_nettype none
module pdrf_host (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr = 8'h00,
  output var  logic        s_axi_awvalid = 1'b0,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata = 32'h0,
  output var  logic [3:0]  s_axi_wstrb = 4'h0,
  output var  logic        s_axi_wvalid = 1'b0,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready = 1'b0,
  output var  logic [7:0]  s_axi_araddr = 8'h00,
  output var  logic        s_axi_arvalid = 1'b0,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready = 1'b0
);
  // each handshake is sampled at the rising edge that completes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic b_t;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      b_t = s_axi_bvalid;
      r   = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic r_t;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      r_t = s_axi_rvalid;
      d   = s_axi_rdata;
      r   = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : pdrf_host
`default_nettype wire

// ===== testbench/pdrf_top_asserts.sv
// bus and decode checker for the phase-detect and rf-switch register block
`timescale 1ns/100ps
`default_nettype none
module pdrf_top_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       header_in,
  input wire logic       alternate_mode_select,
  input wire logic       legacy_compat_select,
  input wire logic [2:0] phase_pulse_stretch_sel,
  input wire logic [2:0] stretch_step,
  input wire logic [1:0] phase_lpf_sel,
  input wire logic       rf_lowpass_en,
  input wire logic       data_switch_active,
  input wire logic       input_d_mute,
  input wire logic       input_a_invert
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response not on time");
  a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address accepted while one is held");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    !s_axi_arready) else $error("read answer not on time");
  a_switch_quiet: assert property ($past(aresetn) &&
    !$stable({input_d_mute, input_a_invert}) |-> $past(s_axi_bvalid))
    else $error("switch outputs moved without a write");
  a_rf_follows_alt: assert property ($past(aresetn) |->
    rf_lowpass_en == !$past(alternate_mode_select)) else $error("rf enable wrong");
  a_legacy_off: assert property (!legacy_compat_select && rf_lowpass_en |->
    stretch_step == 3'h0 && phase_lpf_sel == 2'h0) else $error("legacy fields used");
  a_stretch_fwd: assert property (legacy_compat_select && rf_lowpass_en &&
    phase_pulse_stretch_sel <= 3'h4 |-> stretch_step == phase_pulse_stretch_sel)
    else $error("forward stretch wrong");
  a_stretch_rev: assert property ($past(aresetn) && !rf_lowpass_en &&
    phase_pulse_stretch_sel <= 3'h4 |-> stretch_step == 3'h4 - phase_pulse_stretch_sel &&
    phase_lpf_sel == 2'h0) else $error("reversed stretch wrong");
  a_hdr_select: assert property ($past(aresetn) |->
    data_switch_active == !$past(header_in)) else $error("data switch select wrong");
endmodule : pdrf_top_asserts
bind pdrf_top pdrf_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .header_in, .alternate_mode_select, .legacy_compat_select,
  .phase_pulse_stretch_sel, .stretch_step, .phase_lpf_sel, .rf_lowpass_en,
  .data_switch_active, .input_d_mute, .input_a_invert);
`default_nettype wire

// ===== testbench/pdrf_top_bench.sv
// self-checking bench for the phase-detect and rf-switch register block
`timescale 1ns/100ps
`default_nettype none
module pdrf_top_bench;
  import pdrf_pkg::*;
  logic aclk, aresetn, header_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sw_vec;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, phase_lpf_sel, leadlag_start_freq_sel;
  logic alternate_mode_select, legacy_compat_select, phase_factory_test_bit, rf_lowpass_en;
  logic [2:0] phase_pulse_stretch_sel, stretch_step, rf_lowpass_select;
  logic data_switch_active, input_d_mute, input_d_invert, input_c_mute, input_c_invert;
  logic input_b_mute, input_b_invert, input_a_mute, input_a_invert;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  assign sw_vec = {input_d_mute, input_d_invert, input_c_mute, input_c_invert,
                   input_b_mute, input_b_invert, input_a_mute, input_a_invert};
  pdrf_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .header_in, .alternate_mode_select, .legacy_compat_select,
    .phase_factory_test_bit, .phase_pulse_stretch_sel, .stretch_step, .phase_lpf_sel,
    .rf_lowpass_select, .rf_lowpass_en, .leadlag_start_freq_sel, .data_switch_active,
    .input_d_mute, .input_d_invert, .input_c_mute, .input_c_invert, .input_b_mute,
    .input_b_invert, .input_a_mute, .input_a_invert);
  pdrf_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    logic [1:0] r;
    host.wr(a, d, s, r);
    chk("bresp", {30'h0, r}, {30'h0, er});
    @(posedge aclk);
    #1;
  endtask : put
  task automatic get(input string nm, input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    chk(nm, d, ed);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : get
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    get("config", OFS_CONFIG, 32'h0, RESP_OKAY);
    get("status", OFS_STATUS, 32'h0020_4000, RESP_OKAY);
  endtask : do_reset
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    aresetn = 1'b0;
    header_in = 1'b0;
    do_reset();
    get("switch read", OFS_SWITCH, 32'h0, RESP_OKAY);
    get("unmapped read", 8'h10, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 8; i += 2) begin
      put(OFS_SWITCH, 32'h8f00 | (32'h1 << i), 4'hf, RESP_OKAY);
      chk("switch inverts", {24'h0, sw_vec}, 32'h1 << i);
    end
    for (int i = 1; i < 8; i += 2) begin
      put(OFS_SWITCH, 32'h8f00 | (32'h1 << i), 4'hf, RESP_OKAY);
      chk("switch mutes", {24'h0, sw_vec}, 32'h1 << i);
    end
    put(OFS_SWITCH, 32'h9055, 4'hf, RESP_SLVERR);
    put(OFS_SWITCH, 32'h8055, 4'h1, RESP_SLVERR);
    chk("switch kept", {24'h0, sw_vec}, 32'h80);
    put(OFS_STATUS, 32'h0, 4'hf, RESP_SLVERR);
    put(8'h10, 32'h0, 4'hf, RESP_SLVERR);
    @(posedge aclk);
    header_in <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk("header select", {31'h0, data_switch_active}, 32'h0);
    @(posedge aclk);
    header_in <= 1'b0;
    put(OFS_PHASE, 32'h7985, 4'hf, RESP_OKAY);
    chk("test bit", {31'h0, phase_factory_test_bit}, 32'h0);
    chk("legacy step", {29'h0, stretch_step}, 32'h0);
    chk("legacy lpf", {30'h0, phase_lpf_sel}, 32'h0);
    chk("rf select", {29'h0, rf_lowpass_select}, 32'h1);
    chk("leadlag", {30'h0, leadlag_start_freq_sel}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      put(OFS_CONFIG, 32'(m), 4'hf, RESP_OKAY);
      get("config", OFS_CONFIG, 32'(m), RESP_OKAY);
      chk("alt out", {31'h0, alternate_mode_select}, 32'(m));
      for (int c = 0; c < 5; c++) begin
        put(OFS_PHASE, 32'h7820 | (32'(c) << 7), 4'hf, RESP_OKAY);
        chk("step", {29'h0, stretch_step}, (m == 1) ? 32'(4 - c) : 32'(c));
        chk("lpf", {30'h0, phase_lpf_sel}, (m == 1) ? 32'h0 : 32'h2);
        chk("rf enable", {31'h0, rf_lowpass_en}, 32'(1 - m));
      end
    end
    put(OFS_CONFIG, 32'h0, 4'hf, RESP_OKAY);
    for (int f = 0; f < 4; f++) begin
      put(OFS_PHASE, 32'h7020 | 32'(f), 4'hf, RESP_OKAY);
      chk("leadlag", {30'h0, leadlag_start_freq_sel}, (f == 3) ? 32'h2 : 32'(f));
    end
    get("status", OFS_STATUS, 32'h0230_6800, RESP_OKAY);
    put(OFS_PHASE, 32'h6981, 4'hf, RESP_SLVERR);
    chk("leadlag kept", {30'h0, leadlag_start_freq_sel}, 32'h2);
    put(OFS_PHASE, 32'h7ba0, 4'hf, RESP_OKAY);
    chk("step clamp", {29'h0, stretch_step}, 32'h4);
    do_reset();
    report_and_stop();
  end
endmodule : pdrf_top_bench
`default_nettype wire

// ===== verilog/pdrf_cfg_if.sv
// stored control words passed from the register file to the decoder
`timescale 1ns/100ps
`default_nettype none
interface pdrf_cfg_if;
  logic [15:0] phase_word;
  logic [15:0] switch_word;
  logic        alt_mode;
  logic        header_in;
  modport src (output phase_word, output switch_word, output alt_mode, output header_in);
  modport dec (input phase_word, input switch_word, input alt_mode, input header_in);
endinterface : pdrf_cfg_if
`default_nettype wire

// ===== verilog/pdrf_decode.sv
// decodes stored control words into registered analogue-path settings
`timescale 1ns/100ps
`default_nettype none
module pdrf_decode (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  pdrf_cfg_if.dec             cfg,
  output var  pdrf_pkg::pdrf_dec_t dec
);
  import pdrf_pkg::*;

  // ****************************************************************
  // stretch code to rising step index
  // ****************************************************************
  function automatic logic [2:0] step_of(input logic [2:0] code, input logic alt);
    logic [2:0] c;
    c = (code > STRETCH_MAX) ? STRETCH_MAX : code;
    step_of = alt ? 3'(STRETCH_MAX - c) : c;
  endfunction : step_of

  pdrf_dec_t dec_d;
  pdrf_dec_t dec_q;
  logic      legacy;
  logic [2:0] str_code;

  always_comb begin
    legacy   = cfg.phase_word[LEGACY_BIT];
    str_code = cfg.phase_word[STR_LSB +: 3];
    dec_d    = '0;
    dec_d.legacy_compat_select   = legacy;
    dec_d.phase_factory_test_bit = cfg.phase_word[TEST_BIT];
    dec_d.phase_pulse_stretch_sel = str_code;
    if (cfg.alt_mode) begin
      dec_d.stretch_step  = step_of(str_code, 1'b1);
      dec_d.phase_lpf_sel = LEGACY_LPF;
    end else if (legacy) begin
      dec_d.stretch_step  = step_of(str_code, 1'b0);
      dec_d.phase_lpf_sel = cfg.phase_word[LPF_LSB +: 2];
    end else begin
      dec_d.stretch_step  = LEGACY_STEP;
      dec_d.phase_lpf_sel = LEGACY_LPF;
    end
    dec_d.rf_lowpass_select      = cfg.phase_word[RF_LSB +: 3];
    dec_d.rf_lowpass_en          = ~cfg.alt_mode;
    dec_d.leadlag_start_freq_sel = cfg.phase_word[FS_LSB +: 2];
    dec_d.input_mute   = {cfg.switch_word[SW_D_MUTE], cfg.switch_word[SW_C_MUTE],
                          cfg.switch_word[SW_B_MUTE], cfg.switch_word[SW_A_MUTE]};
    dec_d.input_invert = {cfg.switch_word[SW_D_INV], cfg.switch_word[SW_C_INV],
                          cfg.switch_word[SW_B_INV], cfg.switch_word[SW_A_INV]};
    dec_d.data_switch_active = ~cfg.header_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign dec = dec_q;
endmodule : pdrf_decode
`default_nettype wire

// ===== verilog/pdrf_pkg.sv
// constants and types for the phase-detect and rf-switch configuration block
package pdrf_pkg;

  // ****************************************************************
  // bus map
  // ****************************************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CONFIG    = 8'h00;
  localparam logic [7:0]  OFS_PHASE     = 8'h04;
  localparam logic [7:0]  OFS_SWITCH    = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // control word layout
  // ****************************************************************
  localparam int          NIB_LSB       = 12;
  localparam logic [3:0]  NIB_PHASE     = 4'h7;
  localparam logic [3:0]  NIB_SWITCH    = 4'h8;
  localparam int          LPF_LSB       = 10;
  localparam int          STR_LSB       = 7;
  localparam int          TEST_BIT      = 6;
  localparam int          LEGACY_BIT    = 5;
  localparam int          RF_LSB        = 2;
  localparam int          FS_LSB        = 0;
  localparam int          ALT_BIT       = 0;
  localparam int          SW_D_MUTE     = 7;
  localparam int          SW_D_INV      = 6;
  localparam int          SW_C_MUTE     = 5;
  localparam int          SW_C_INV      = 4;
  localparam int          SW_B_MUTE     = 3;
  localparam int          SW_B_INV      = 2;
  localparam int          SW_A_MUTE     = 1;
  localparam int          SW_A_INV      = 0;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [15:0] PHASE_RST     = 16'h7000;
  localparam logic [15:0] SWITCH_RST    = 16'h8000;
  localparam logic        ALT_RST       = 1'h0;
  localparam logic [2:0]  STRETCH_MAX   = 3'h4;
  localparam logic [2:0]  LEGACY_STEP   = 3'h0;
  localparam logic [1:0]  LEGACY_LPF    = 2'h0;
  localparam logic [1:0]  FS_UNUSED     = 2'h3;

  typedef struct packed {
    logic       legacy_compat_select;
    logic       phase_factory_test_bit;
    logic [2:0] phase_pulse_stretch_sel;
    logic [2:0] stretch_step;
    logic [1:0] phase_lpf_sel;
    logic [2:0] rf_lowpass_select;
    logic       rf_lowpass_en;
    logic [1:0] leadlag_start_freq_sel;
    logic [3:0] input_mute;
    logic [3:0] input_invert;
    logic       data_switch_active;
  } pdrf_dec_t;

endpackage : pdrf_pkg

// ===== verilog/pdrf_top.sv
// axi4-lite register file for phase-detect filter control and data-channel switch words
//
// Overview of operation
// - stretch code 0..4 rises 1.9 to 30 ns; alternate mode reverses order
// - legacy select low ignores filter and stretch fields outside alternate mode, predecessor behaviour
// - legacy select high applies programmed stretch setting, and filter setting only outside alternate mode
// - rf low-pass field selects bandwidth; no effect in alternate mode
// - lead/lag start code 00/01/10 valid; code 11 never written
// - word with address nibble 1000 stored as data switch; used header low
// - switch bit 7 mutes input d
// - switch bit 6 inverts input d
// - switch bit 5 mutes input c
// - switch bit 4 inverts input c
// - switch bit 3 mutes input b
// - switch bit 2 inverts input b
// - switch bit 1 mutes input a
// - switch bit 0 inverts input a
`timescale 1ns/100ps
`default_nettype none
module pdrf_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [pdrf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [pdrf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       header_in,
  output logic                            alternate_mode_select,
  output logic                            legacy_compat_select,
  output logic                            phase_factory_test_bit,
  output logic [2:0]                      phase_pulse_stretch_sel,
  output logic [2:0]                      stretch_step,
  output logic [1:0]                      phase_lpf_sel,
  output logic [2:0]                      rf_lowpass_select,
  output logic                            rf_lowpass_en,
  output logic [1:0]                      leadlag_start_freq_sel,
  output logic                            data_switch_active,
  output logic                            input_d_mute,
  output logic                            input_d_invert,
  output logic                            input_c_mute,
  output logic                            input_c_invert,
  output logic                            input_b_mute,
  output logic                            input_b_invert,
  output logic                            input_a_mute,
  output logic                            input_a_invert
);
  import pdrf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic              aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              alt;
    logic [15:0]       phase;
    logic [15:0]       switch_w;
    logic [7:0]        reject_cnt;
  } pdrf_regs_t;

  pdrf_regs_t st_q;
  pdrf_regs_t st_d;
  pdrf_dec_t  dec;

  pdrf_cfg_if cfg ();

  // a control word counts only when both low byte lanes arrive with the right nibble
  function automatic logic word_ok(input logic [31:0] d, input logic [3:0] s,
                                   input logic [3:0] nib);
    word_ok = (s[1:0] == 2'h3) && (d[NIB_LSB +: 4] == nib);
  endfunction : word_ok

  function automatic logic [31:0] status_word(input pdrf_dec_t d, input logic [7:0] rej);
    status_word = {rej, 2'h0, d.data_switch_active, d.legacy_compat_select,
                   d.stretch_step, d.phase_lpf_sel, d.rf_lowpass_en,
                   d.leadlag_start_freq_sel, d.input_mute, d.input_invert, 4'h0};
  endfunction : status_word

  // ****************************************************************
  // next state
  // ****************************************************************
  logic do_write;
  logic do_read;

  always_comb begin
    st_d     = st_q;
    do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    do_read  = s_axi_arvalid && !st_q.rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (do_write) begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = RESP_OKAY;
      unique case (st_q.aw_addr)
        OFS_CONFIG: begin
          if (st_q.w_strb[0]) begin
            st_d.alt = st_q.w_data[ALT_BIT];
          end
        end
        OFS_PHASE: begin
          if (word_ok(st_q.w_data, st_q.w_strb, NIB_PHASE)) begin
            st_d.phase = st_q.w_data[15:0];
            if (st_q.w_data[FS_LSB +: 2] == FS_UNUSED) begin
              st_d.phase[FS_LSB +: 2] = st_q.phase[FS_LSB +: 2];
            end
          end else begin
            st_d.bresp      = RESP_SLVERR;
            st_d.reject_cnt = 8'(st_q.reject_cnt + 8'h1);
          end
        end
        OFS_SWITCH: begin
          if (word_ok(st_q.w_data, st_q.w_strb, NIB_SWITCH)) begin
            st_d.switch_w = {NIB_SWITCH, 4'h0, st_q.w_data[7:0]};
          end else begin
            st_d.bresp      = RESP_SLVERR;
            st_d.reject_cnt = 8'(st_q.reject_cnt + 8'h1);
          end
        end
        OFS_STATUS: begin
          st_d.bresp = RESP_SLVERR;
        end
        default: begin
          st_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (do_read) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CONFIG: begin
          st_d.rdata = {31'h0, st_q.alt};
        end
        OFS_PHASE: begin
          st_d.rdata = 32'h0;
        end
        OFS_SWITCH: begin
          st_d.rdata = 32'h0;
        end
        OFS_STATUS: begin
          st_d.rdata = status_word(dec, st_q.reject_cnt);
        end
        default: begin
          st_d.rdata = 32'h0;
          st_d.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q            <= '0;
      st_q.alt        <= ALT_RST;
      st_q.phase      <= PHASE_RST;
      st_q.switch_w   <= SWITCH_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  assign s_axi_awready = !st_q.aw_held;
  assign s_axi_wready  = !st_q.w_held;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

  // ****************************************************************
  // decoder
  // ****************************************************************
  assign cfg.phase_word  = st_q.phase;
  assign cfg.switch_word = st_q.switch_w;
  assign cfg.alt_mode    = st_q.alt;
  assign cfg.header_in   = header_in;

  pdrf_decode u_decode (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (cfg.dec),
    .dec     (dec)
  );

  // ****************************************************************
  // analogue-path outputs
  // ****************************************************************
  assign alternate_mode_select   = st_q.alt;
  assign legacy_compat_select    = dec.legacy_compat_select;
  assign phase_factory_test_bit  = dec.phase_factory_test_bit;
  assign phase_pulse_stretch_sel = dec.phase_pulse_stretch_sel;
  assign stretch_step            = dec.stretch_step;
  assign phase_lpf_sel           = dec.phase_lpf_sel;
  assign rf_lowpass_select       = dec.rf_lowpass_select;
  assign rf_lowpass_en           = dec.rf_lowpass_en;
  assign leadlag_start_freq_sel  = dec.leadlag_start_freq_sel;
  assign data_switch_active      = dec.data_switch_active;
  assign input_d_mute            = dec.input_mute[3];
  assign input_d_invert          = dec.input_invert[3];
  assign input_c_mute            = dec.input_mute[2];
  assign input_c_invert          = dec.input_invert[2];
  assign input_b_mute            = dec.input_mute[1];
  assign input_b_invert          = dec.input_invert[1];
  assign input_a_mute            = dec.input_mute[0];
  assign input_a_invert          = dec.input_invert[0];

endmodule : pdrf_top
`default_nettype wire
